/* File: shared/wwdt_pkg.sv */
package wwdt_pkg;
  // Register byte offsets on the bus
  localparam logic [3:0] REG_CTRL_OFS = 4'h0;
  localparam logic [3:0] REG_CODE_OFS = 4'h4;
  localparam logic [3:0] REG_COUNT_OFS = 4'h8;
  localparam logic [3:0] REG_STAT_OFS = 4'hc;

  // Control codes
  localparam logic [7:0] CODE_CLEAR = 8'h4e;
  localparam logic [7:0] CODE_DISABLE = 8'hb1;

  // Control register fields
  localparam int CTRL_ACT_BIT = 0;
  localparam int CTRL_PER_LSB = 1;
  localparam int CTRL_WIN_LSB = 3;
  localparam int CTRL_EN_BIT = 7;

  // Status register fields and reserved bits read value
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_EARLY_BIT = 1;
  localparam int STAT_OVF_BIT = 2;
  localparam logic [7:0] STAT_RSVD = 8'h58;

  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CNT_RESET = 8'h00;

  // Counter top and clear window opening counts
  localparam logic [7:0] CNT_MAX = 8'hff;
  localparam logic [7:0] WIN_OPEN_1 = 8'h40;
  localparam logic [7:0] WIN_OPEN_2 = 8'h80;
  localparam logic [7:0] WIN_OPEN_3 = 8'hc0;

  // Source tick timing at the shortest overflow period
  localparam int CLK_PERIOD_NS = 50;
  localparam int TICK_PERIOD_NS = 128000;
  localparam int TICK_BASE_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PRE_W = 18;

  // Bus data phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_WRITE = 2'b10
  } wwdt_phase_t;
endpackage

/* File: shared/wwdt_tick_if.sv */
interface wwdt_tick_if;
  logic run;
  logic restart;
  logic [1:0] period_sel;
  logic tick;

  modport ctl (output run, output restart, output period_sel, input tick);
  modport pre (input run, input restart, input period_sel, output tick);
endinterface

/* File: hdl/wwdt_prescale.sv */
module wwdt_prescale #(
  parameter int unsigned TICK_BASE = wwdt_pkg::TICK_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  wwdt_tick_if.pre tp
);
  logic [wwdt_pkg::PRE_W-1:0] pre_q;
  logic [wwdt_pkg::PRE_W-1:0] lim;
  logic tick_q;

  // Base count must fit the divider at the longest period
  if (TICK_BASE < 2 || TICK_BASE * 64 >= (1 << wwdt_pkg::PRE_W)) begin : g_chk
    $error("wwdt_prescale: TICK_BASE out of range");
  end

  // Ticks per period select, four times longer each step
  always_comb begin
    lim = wwdt_pkg::PRE_W'(TICK_BASE) << {tp.period_sel, 1'b0};
  end

  // Divider, held at zero while stopped or restarted
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= '0;
      tick_q <= 1'b0;
    end else if (!tp.run || tp.restart) begin
      pre_q <= '0;
      tick_q <= 1'b0;
    end else if (pre_q >= lim - 1'b1) begin
      pre_q <= '0;
      tick_q <= 1'b1;
    end else begin
      pre_q <= pre_q + 1'b1;
      tick_q <= 1'b0;
    end
  end

  assign tp.tick = tick_q;

  property p_no_tick_stopped;
    @(posedge i_clk) disable iff (!i_rst_n)
    !tp.run |=> !tp.tick;
  endproperty
  a_no_tick_stopped: assert property (p_no_tick_stopped)
    else $error("source tick while stopped");

  property p_tick_pulse;
    @(posedge i_clk) disable iff (!i_rst_n)
    tp.tick |=> !tp.tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse)
    else $error("source tick longer than one cycle");
endmodule

/* File: hdl/wwdt_top.sv */
// Chosen here: the AHB-Lite register port and the address map.
module wwdt_top #(
  parameter int unsigned TICK_BASE = wwdt_pkg::TICK_BASE_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_warmup_done,
  input wire logic i_pause,
  output logic o_nmi_req,
  output logic o_rst_req
);
  wwdt_tick_if tp ();

  wwdt_pkg::wwdt_phase_t ph_q;
  logic [3:0] ofs_q;
  logic hit_q;
  logic take;
  logic hit;
  logic rd_stat;
  logic wr_ctrl;
  logic wr_code;
  logic [7:0] code;
  logic warm_q;
  logic enable_q;
  logic act_q;
  logic [1:0] per_q;
  logic [1:0] win_q;
  logic run_q;
  logic [7:0] cnt_q;
  logic ovf_flag_q;
  logic early_q;
  logic [7:0] win_open;
  logic in_win;
  logic tick;
  logic clr_wr;
  logic clr_ok;
  logic clr_early;
  logic dis_wr;
  logic ovf;
  logic ovf_irq;
  logic [7:0] stat;

  // Address phase decode, only single word transfers are expected
  assign take = i_hsel && i_htrans[1] && i_hready;
  assign hit = (i_haddr[11:4] == 8'h00) && (i_haddr[1:0] == 2'b00) && (i_hsize == 3'b010);
  assign rd_stat = take && !i_hwrite && hit && (i_haddr[3:0] == wwdt_pkg::REG_STAT_OFS);

  // Data phase write strobes
  assign wr_ctrl = (ph_q == wwdt_pkg::PH_WRITE) && hit_q && (ofs_q == wwdt_pkg::REG_CTRL_OFS);
  assign wr_code = (ph_q == wwdt_pkg::PH_WRITE) && hit_q && (ofs_q == wwdt_pkg::REG_CODE_OFS);
  assign code = i_hwdata[7:0];

  // Bus phase tracking
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ph_q <= wwdt_pkg::PH_IDLE;
      ofs_q <= 4'h0;
      hit_q <= 1'b0;
    end else if (i_hready) begin
      ph_q <= (take && i_hwrite) ? wwdt_pkg::PH_WRITE : wwdt_pkg::PH_IDLE;
      ofs_q <= i_haddr[3:0];
      hit_q <= hit;
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // Status word with fixed reserved bits
  always_comb begin
    stat = wwdt_pkg::STAT_RSVD;
    stat[wwdt_pkg::STAT_RUN_BIT] = run_q;
    stat[wwdt_pkg::STAT_EARLY_BIT] = early_q;
    stat[wwdt_pkg::STAT_OVF_BIT] = ovf_flag_q;
  end

  // Read data captured at the address phase
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (take && !i_hwrite) begin
      if (!hit) begin
        o_hrdata <= 32'h0000_0000;
      end else begin
        case (i_haddr[3:0])
          wwdt_pkg::REG_CTRL_OFS: o_hrdata <= {24'h00_0000, enable_q, 2'b00, win_q, per_q, act_q};
          wwdt_pkg::REG_COUNT_OFS: o_hrdata <= {24'h00_0000, cnt_q};
          wwdt_pkg::REG_STAT_OFS: o_hrdata <= {24'h00_0000, stat};
          default: o_hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Warm-up seen, enables the watchdog once
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      warm_q <= 1'b0;
    end else if (i_warmup_done) begin
      warm_q <= 1'b1;
    end
  end

  // Control register
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_q <= wwdt_pkg::CTRL_RESET[wwdt_pkg::CTRL_EN_BIT];
      act_q <= wwdt_pkg::CTRL_RESET[wwdt_pkg::CTRL_ACT_BIT];
      per_q <= wwdt_pkg::CTRL_RESET[wwdt_pkg::CTRL_PER_LSB +: 2];
      win_q <= wwdt_pkg::CTRL_RESET[wwdt_pkg::CTRL_WIN_LSB +: 2];
    end else if (i_warmup_done && !warm_q) begin
      enable_q <= 1'b1;
    end else if (wr_ctrl) begin
      enable_q <= i_hwdata[wwdt_pkg::CTRL_EN_BIT];
      act_q <= i_hwdata[wwdt_pkg::CTRL_ACT_BIT];
      per_q <= i_hwdata[wwdt_pkg::CTRL_PER_LSB +: 2];
      win_q <= i_hwdata[wwdt_pkg::CTRL_WIN_LSB +: 2];
    end
  end

  // Clear window opening count
  always_comb begin
    case (win_q)
      2'b01: win_open = wwdt_pkg::WIN_OPEN_1;
      2'b10: win_open = wwdt_pkg::WIN_OPEN_2;
      2'b11: win_open = wwdt_pkg::WIN_OPEN_3;
      default: win_open = wwdt_pkg::CNT_RESET;
    endcase
  end
  assign in_win = (win_q == 2'b00) || (cnt_q >= win_open);

  // Code decode; any other code value falls through untouched
  assign clr_wr = wr_code && (code == wwdt_pkg::CODE_CLEAR);
  assign dis_wr = wr_code && (code == wwdt_pkg::CODE_DISABLE) && !enable_q;
  assign clr_ok = clr_wr && run_q && in_win;
  assign clr_early = clr_wr && run_q && !in_win;

  // Overflow; clear or disable in the same cycle wins
  assign tick = tp.tick && tp.run;
  assign ovf = tick && (cnt_q == wwdt_pkg::CNT_MAX) && run_q && !clr_ok && !dis_wr;
  assign ovf_irq = ovf && !act_q;

  // Prescaler control, paused in low power modes and warm-up
  assign tp.run = run_q && warm_q && !i_pause;
  assign tp.restart = clr_ok || dis_wr;
  assign tp.period_sel = per_q;

  wwdt_prescale #(
    .TICK_BASE(TICK_BASE)
  ) u_pre (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .tp(tp)
  );

  // Operating state
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
    end else if (dis_wr) begin
      run_q <= 1'b0;
    end else if (enable_q) begin
      run_q <= 1'b1;
    end
  end

  // Up counter
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= wwdt_pkg::CNT_RESET;
    end else if (clr_ok || dis_wr) begin
      cnt_q <= wwdt_pkg::CNT_RESET;
    end else if (tick) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Cause flags, a set beats the read clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ovf_flag_q <= 1'b0;
      early_q <= 1'b0;
    end else begin
      if (ovf_irq) begin
        ovf_flag_q <= 1'b1;
      end else if (rd_stat) begin
        ovf_flag_q <= 1'b0;
      end
      if (clr_early) begin
        early_q <= 1'b1;
      end else if (rd_stat) begin
        early_q <= 1'b0;
      end
    end
  end

  // Requests: interrupt ungated and issued each event, reset to the chip
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_nmi_req <= 1'b0;
      o_rst_req <= 1'b0;
    end else begin
      o_nmi_req <= ovf_irq || clr_early;
      o_rst_req <= ovf && act_q;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  property p_ovf_nmi;
    ovf && !act_q |=> o_nmi_req && ovf_flag_q && !o_rst_req;
  endproperty
  a_ovf_nmi: assert property (p_ovf_nmi)
    else $error("overflow did not raise interrupt");

  property p_nmi_unmasked;
    clr_early |=> o_nmi_req;
  endproperty
  a_nmi_unmasked: assert property (p_nmi_unmasked)
    else $error("interrupt request was held back");

  property p_nmi_back_to_back;
    (ovf_irq || clr_early) ##1 (ovf_irq || clr_early) |=> o_nmi_req && $past(o_nmi_req);
  endproperty
  a_nmi_back_to_back: assert property (p_nmi_back_to_back)
    else $error("second interrupt request lost");

  property p_ovf_rst;
    ovf && act_q |=> o_rst_req && !o_nmi_req;
  endproperty
  a_ovf_rst: assert property (p_ovf_rst)
    else $error("overflow did not raise reset request");

  property p_rst_cause;
    o_rst_req |-> $past(act_q) && $past(cnt_q) == wwdt_pkg::CNT_MAX;
  endproperty
  a_rst_cause: assert property (p_rst_cause)
    else $error("reset request without overflow");

  property p_clear;
    clr_ok |=> cnt_q == wwdt_pkg::CNT_RESET;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear code did not zero counter");

  property p_disable;
    wr_code && code == wwdt_pkg::CODE_DISABLE |=> run_q == $past(enable_q);
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable code misapplied");

  property p_clear_beats_ovf;
    clr_ok && tick && cnt_q == wwdt_pkg::CNT_MAX
      |=> !o_rst_req && !o_nmi_req && cnt_q == wwdt_pkg::CNT_RESET;
  endproperty
  a_clear_beats_ovf: assert property (p_clear_beats_ovf)
    else $error("overflow registered despite clear");

  property p_count_read;
    take && !i_hwrite && hit && i_haddr[3:0] == wwdt_pkg::REG_COUNT_OFS
      |=> o_hrdata == {24'h00_0000, $past(cnt_q)};
  endproperty
  a_count_read: assert property (p_count_read)
    else $error("counter read mismatch");

  property p_run_flag;
    rd_stat |=> o_hrdata[wwdt_pkg::STAT_RUN_BIT] == $past(run_q);
  endproperty
  a_run_flag: assert property (p_run_flag)
    else $error("operating flag mismatch");

  property p_early;
    clr_early |=> early_q && (cnt_q == $past(cnt_q) || cnt_q == $past(cnt_q) + 8'h01);
  endproperty
  a_early: assert property (p_early)
    else $error("early clear not flagged");

  property p_read_clear;
    rd_stat && !ovf_irq && !clr_early |=> !ovf_flag_q && !early_q;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("status read did not clear flags");

  property p_set_wins;
    rd_stat && ovf_irq |=> ovf_flag_q;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("flag lost to read clear");

  property p_warm_enable;
    i_warmup_done && !warm_q |=> enable_q ##1 run_q;
  endproperty
  a_warm_enable: assert property (p_warm_enable)
    else $error("warm-up did not enable watchdog");

  property p_pause;
    i_pause && !clr_ok && !dis_wr ##1 i_pause && !clr_ok && !dis_wr |=> $stable(cnt_q);
  endproperty
  a_pause: assert property (p_pause)
    else $error("counter moved while paused");

  property p_other_code;
    wr_code && code != wwdt_pkg::CODE_CLEAR && code != wwdt_pkg::CODE_DISABLE |=> $stable(run_q);
  endproperty
  a_other_code: assert property (p_other_code)
    else $error("stray code changed state");

  c_ovf_nmi: cover property (ovf_irq);
  c_ovf_rst: cover property (ovf && act_q);
  c_early: cover property (clr_early);
  c_disable: cover property (dis_wr);
endmodule

/* File: verif/wwdt_cpu_model.sv */
module wwdt_cpu_model #(
  parameter int WARM = 20
) (
  input wire logic i_clk,
  input wire logic i_por_n,
  input wire logic i_int_master_en,
  input wire logic i_nmi_req,
  input wire logic i_rst_req,
  output logic o_rst_n,
  output logic o_warmup_done,
  output int o_nest,
  output int o_resets
);
  timeunit 1ns;
  timeprecision 1ps;
  int hold;
  int warm;
  // Every request is taken whatever the master enable says; no return, so levels pile up
  always @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      o_nest <= 0;
    end else if (i_nmi_req) begin
      o_nest <= o_nest + 1;
    end
  end
  // Chip reset on request, then warm-up before enable
  always @(posedge i_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      hold <= 0;
      warm <= 0;
      o_resets <= 0;
    end else if (i_rst_req) begin
      hold <= 3;
      warm <= 0;
      o_resets <= o_resets + 1;
    end else if (hold > 0) begin
      hold <= hold - 1;
    end else if (warm < WARM) begin
      warm <= warm + 1;
    end
  end
  assign o_rst_n = i_por_n && (hold == 0);
  assign o_warmup_done = (warm >= WARM);
endmodule

/* File: verif/wwdt_top_tb.sv */
module wwdt_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TB = 4;
  localparam logic [31:0] CT = 32'h0;
  localparam logic [31:0] CD = 32'h4;
  localparam logic [31:0] CN = 32'h8;
  localparam logic [31:0] ST = 32'hc;
  logic clk = 1'b0;
  logic por_n, rst_n, hsel, hwrite, hrdy, hresp, warm, pause, nmi, rreq;
  logic [31:0] haddr, hwdata, hrdata, v, a, b;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int nest, resets, polls;
  int failures = 0;
  int checks = 0;
  int seed = 32'h3ad2;

  always #25 clk = ~clk;

  wwdt_cpu_model u_wwdt_cpu_model (.i_clk(clk), .i_por_n(por_n), .i_int_master_en(1'b0),
    .i_nmi_req(nmi), .i_rst_req(rreq), .o_rst_n(rst_n), .o_warmup_done(warm),
    .o_nest(nest), .o_resets(resets));

  wwdt_top #(.TICK_BASE(TB)) u_wwdt_top (.i_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
    .o_hresp(hresp), .i_warmup_done(warm), .i_pause(pause), .o_nmi_req(nmi),
    .o_rst_req(rreq));

  // Expected status word from flag values
  function automatic logic [31:0] st(input int ovf, input int early, input int run);
    return 32'h58 | (ovf << 2) | (early << 1) | run;
  endfunction

  task automatic tally_and_finish;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h range %h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    chk({31'h0, hrdy}, 32'h1);
  endtask

  // One single word transfer, address phase then data phase
  task automatic bus(input logic wr, input logic [31:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= ad;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [31:0] ad, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, ad, d, x);
  endtask

  task automatic rd_chk(input logic [31:0] ad, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, ad, 32'h0, x);
    chk(x, exp);
  endtask

  task automatic rd_rng(input logic [31:0] ad, input logic [31:0] lo, input logic [31:0] hi);
    logic [31:0] x;
    bus(1'b0, ad, 32'h0, x);
    chk_rng(x, lo, hi);
  endtask

  // Wait for a request pulse, reset one when rs is set
  task automatic wait_pulse(input bit rs);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while ((rs ? rreq : nmi) !== 1'b1 && n < 1300);
    chk({31'h0, n < 1300}, 32'h1);
    @(posedge clk);
  endtask

  // Main sequence
  initial begin
    por_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    pause = 1'b0;
    repeat (3) @(posedge clk);
    por_n <= 1'b1;
    @(posedge clk);
    rd_chk(CT, 32'h0);
    rd_chk(ST, st(0, 0, 0));
    idle(25);
    rd_chk(CT, 32'h80);
    rd_chk(ST, st(0, 0, 1));
    wr(CD, 32'h4e);
    idle(40);
    rd_rng(CN, 9, 11);
    repeat (3) begin
      v = $random(seed);
      if (v[7:0] == 8'h4e || v[7:0] == 8'hb1)
        v[7:0] = 8'h00;
      wr(CD, {24'h0, v[7:0]});
    end
    rd_rng(CN, 10, 14);
    wr(CD, 32'hb1);
    idle(1);
    rd_chk(ST, st(0, 0, 1));
    wr(CT, 32'h00);
    wr(CD, 32'hb1);
    idle(1);
    rd_chk(ST, st(0, 0, 0));
    idle(40);
    rd_chk(CN, 32'h0);
    wr(CT, 32'h80);
    idle(2);
    rd_chk(ST, st(0, 0, 1));
    // Frozen count while paused, random pause length
    wr(CD, 32'h4e);
    idle(20);
    pause <= 1'b1;
    idle(2);
    bus(1'b0, CN, 32'h0, a);
    idle(20 + ($random(seed) & 63));
    bus(1'b0, CN, 32'h0, b);
    chk(b, a);
    pause <= 1'b0;
    idle(40);
    rd_rng(CN, a + 8, a + 11);
    // Early clear with window 01, status read right behind it
    wr(CT, 32'h88);
    wr(CD, 32'h4e);
    rd_chk(ST, st(0, 1, 1));
    rd_chk(ST, st(0, 0, 1));
    chk(nest, 1);
    rd_rng(CN, a + 11, a + 13);
    idle(64 * TB);
    wr(CD, 32'h4e);
    idle(1);
    rd_rng(CN, 0, 1);
    chk(nest, 1);
    // Overflow to interrupt, twice without return
    wr(CT, 32'h80);
    wait_pulse(1'b0);
    rd_chk(ST, st(1, 0, 1));
    rd_chk(ST, st(0, 0, 1));
    // Second overflow met by back-to-back status reads
    polls = 0;
    v = 32'h0;
    while (v[2] !== 1'b1 && polls < 700) begin
      bus(1'b0, ST, 32'h0, v);
      polls++;
    end
    chk(v, st(1, 0, 1));
    rd_chk(ST, st(0, 0, 1));
    chk(nest, 3);
    chk(resets, 0);
    wr(32'h10, 32'hff);
    rd_chk(32'h10, 32'h0);
    rd_chk(CD, 32'h0);
    // Overflow to chip reset, then warm-up again
    wr(CT, 32'h81);
    wait_pulse(1'b1);
    idle(4);
    rd_chk(CT, 32'h0);
    chk(resets, 1);
    idle(25);
    rd_chk(CT, 32'h80);
    tally_and_finish();
  end

  // Hang guard, well past the expected run
  initial begin
    #1000000;
    failures++;
    tally_and_finish();
  end
endmodule
